// ==== srs_params.svh ====
// Overview of operation
// - Supply below threshold asserts active-low and active-high reset outputs.
// - After supply recovers, resets stay asserted for the timeout, nominally 200 ms.
// - Write-protect input high refuses every memory write.
// - Write-protect low or floating allows writes everywhere; pull-down gives unprotected.
// - Memory writes inhibited while supply low, including power-up before first threshold.
// - Manual push input low asserts resets; held, then full timeout after release.
// - Manual push input is debounced and defaults high through a pull-up.
// - Outside party pulling the reset pin low acts as a manual trigger.
// - Reset pins are open-drain, driving only the asserted level.
// - Reduced variant has only active-low reset and no write-protect input.
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH
`define SRS_CLK_PERIOD_NS   25
`define SRS_TIMEOUT_MS      200
`define SRS_TIMEOUT_CYC     ((`SRS_TIMEOUT_MS * 1000000) / `SRS_CLK_PERIOD_NS)
`define SRS_DEBOUNCE_US     10
`define SRS_DEBOUNCE_CYC    ((`SRS_DEBOUNCE_US * 1000) / `SRS_CLK_PERIOD_NS)
`define SRS_CNT_W           24
`endif

// ==== srs_pkg.sv ====
package srs_pkg;
  typedef enum logic [2:0] {
    SRS_ST_HOLD    = 3'b001,
    SRS_ST_TIMEOUT = 3'b010,
    SRS_ST_RUN     = 3'b100
  } srs_state_t;

  typedef struct packed {
    logic rst_n_oe;
    logic rst_hi_oe;
    logic wr_allow;
  } srs_out_t;
endpackage : srs_pkg

// ==== srs_debounce.sv ====
`timescale 1ns/1ps
`include "srs_params.svh"
module srs_debounce #(
  parameter int unsigned CYC = 400
) (
  input  wire logic clk_sys,   // System clock
  input  wire logic sys_rst,   // Async reset, high
  input  wire logic ce,        // Clock enable
  input  wire logic din,       // Raw level, resets to high
  output logic      dout       // Filtered level
);
  import srs_pkg::*;

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        out;
    logic [15:0] cnt;
  } srs_db_t;

  srs_db_t st_q;
  srs_db_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    // Level must stand unchanged for CYC cycles before it is accepted
    if (st_q.s2 == st_q.out) begin
      st_d.cnt = 16'h0000;
    end else if (st_q.cnt >= 16'(CYC - 1)) begin
      st_d.out = st_q.s2;
      st_d.cnt = 16'h0000;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, out: 1'b1, cnt: 16'h0000};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.out;
endmodule : srs_debounce

// ==== srs_supervisor.sv ====
`timescale 1ns/1ps
`include "srs_params.svh"
module srs_supervisor #(
  parameter int unsigned TIMEOUT_CYC  = `SRS_TIMEOUT_CYC,
  parameter int unsigned DEBOUNCE_CYC = `SRS_DEBOUNCE_CYC,
  parameter bit          REDUCED      = 1'b0
) (
  input  wire logic              clk_sys,           // System clock, 40 MHz
  input  wire logic              sys_rst,           // Async reset, high
  input  wire logic              ce,                // Clock enable
  input  wire logic              supply_low,        // Comparator: supply under threshold
  input  wire logic              manual_push_input, // Manual reset, active low
  input  wire logic              rst_n_in,          // Sensed level of active-low pin
  input  wire logic              wp_in,             // Write-protect level
  input  wire logic              wr_req,            // Memory write request
  output logic                   rst_n_o,           // Active-low pin drive value
  output logic                   rst_n_oe,          // Active-low pin enable
  output logic                   rst_hi_o,          // Active-high pin drive value
  output logic                   rst_hi_oe,         // Active-high pin enable
  output logic                   wr_allow,          // Write permitted this cycle
  output logic                   wr_refused,        // Write request refused
  output srs_pkg::srs_state_t    state_o            // Sequencer state
);
  import srs_pkg::*;

  typedef struct packed {
    logic                   sup_s1;
    logic                   sup_s2;
    logic                   pin_s1;
    logic                   pin_s2;
    logic                   pin_own1;
    logic                   pin_own;
    logic                   powered;
    logic [`SRS_CNT_W-1:0]  cnt;
    srs_state_t             st;
    srs_out_t               out;
    logic                   refused;
  } srs_top_t;

  srs_top_t st_q;
  srs_top_t st_d;
  logic     man_db;
  logic     trig;
  logic     wp_eff;

  // Any state but run keeps the reset pins driven
  function automatic logic srs_asserting_f(srs_state_t s);
    return s != SRS_ST_RUN;
  endfunction : srs_asserting_f

  srs_debounce #(.CYC(DEBOUNCE_CYC)) u_db (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ce      (ce),
    .din     (manual_push_input),
    .dout    (man_db)
  );

  // Floating write protect is low by the pull-down; reduced part ignores it
  assign wp_eff = REDUCED ? 1'b0 : wp_in;

  // Outside pull-low on the pin counts only when we are not driving it.
  // Own drive reaches pin_s2 two edges late, so the ownership flag lags
  // by two stages as well; otherwise our own release would retrigger.
  always_comb begin
    trig = st_q.sup_s2 || !man_db || (!st_q.pin_s2 && !st_q.pin_own && !st_q.pin_own1);
  end

  always_comb begin
    st_d = st_q;
    st_d.sup_s1 = supply_low;
    st_d.sup_s2 = st_q.sup_s1;
    st_d.pin_s1 = rst_n_in;
    st_d.pin_s2 = st_q.pin_s1;
    st_d.pin_own1 = st_q.out.rst_n_oe;
    st_d.pin_own = st_q.pin_own1;
    if (!st_q.sup_s2) begin
      st_d.powered = 1'b1;
    end
    unique case (st_q.st)
      SRS_ST_HOLD: begin
        st_d.cnt = '0;
        if (!trig) begin
          st_d.st = SRS_ST_TIMEOUT;
        end
      end
      SRS_ST_TIMEOUT: begin
        if (trig) begin
          st_d.st = SRS_ST_HOLD;
          st_d.cnt = '0;
        end else if (st_q.cnt >= `SRS_CNT_W'(TIMEOUT_CYC - 1)) begin
          st_d.st = SRS_ST_RUN;
        end else begin
          st_d.cnt = st_q.cnt + 1'b1;
        end
      end
      SRS_ST_RUN: begin
        if (trig) begin
          st_d.st = SRS_ST_HOLD;
        end
      end
    endcase
    // Open-drain: enable only for the asserted level
    st_d.out.rst_n_oe = srs_asserting_f(st_d.st);
    st_d.out.rst_hi_oe = REDUCED ? 1'b0 : srs_asserting_f(st_d.st);
    st_d.out.wr_allow = !st_q.sup_s2 && st_q.powered && !wp_eff;
    st_d.refused = wr_req && !st_q.out.wr_allow;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '{sup_s1: 1'b1, sup_s2: 1'b1, pin_s1: 1'b1, pin_s2: 1'b1, pin_own1: 1'b1, pin_own: 1'b1,
                powered: 1'b0, cnt: '0, st: SRS_ST_HOLD,
                out: '{rst_n_oe: 1'b1, rst_hi_oe: !REDUCED, wr_allow: 1'b0}, refused: 1'b0};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign rst_n_o   = 1'b0;
  assign rst_hi_o  = 1'b1;
  assign rst_n_oe  = st_q.out.rst_n_oe;
  assign rst_hi_oe = st_q.out.rst_hi_oe;
  assign wr_allow  = st_q.out.wr_allow;
  assign wr_refused = st_q.refused;
  assign state_o   = st_q.st;

  AST_SUPPLY_HOLDS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && st_q.sup_s2 |=> rst_n_oe) else $error("Reset released while supply low");
  AST_HI_FOLLOWS_LO: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rst_hi_oe == (rst_n_oe && !REDUCED)) else $error("Reset pins disagree");
  AST_TIMEOUT_MIN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(st_q.st == SRS_ST_RUN) |-> st_q.cnt == `SRS_CNT_W'(TIMEOUT_CYC - 1))
    else $error("Released before timeout");
  AST_WP_BLOCKS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && wp_in && !REDUCED |=> !wr_allow) else $error("Write allowed under protect");
  AST_WP_FREE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && !wp_in && !st_q.sup_s2 && st_q.powered |=> wr_allow) else $error("Write blocked");
  AST_LOW_SUPPLY_NOWR: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && (st_q.sup_s2 || !st_q.powered) |=> !wr_allow) else $error("Write in low supply");
  AST_MANUAL_HOLDS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && !man_db |=> rst_n_oe && st_q.st != SRS_ST_RUN) else $error("Manual reset ignored");
  AST_PIN_TRIGGER: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && st_q.st == SRS_ST_RUN && !st_q.pin_s2 && !st_q.pin_own && !st_q.pin_own1
    |=> st_q.st == SRS_ST_HOLD)
    else $error("External pin pull ignored");
  AST_OPEN_DRAIN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !rst_n_o && rst_hi_o && rst_n_oe == srs_asserting_f(st_q.st))
    else $error("Drive level wrong");

  AST_ONE_HOT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $onehot(st_q.st))
    else $error("State code not one-hot");

  AST_HOLD_ON_TRIG: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && trig |=> st_q.st == SRS_ST_HOLD && rst_n_oe)
    else $error("Trigger did not hold reset");

  AST_HOLD_EXIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && st_q.st == SRS_ST_HOLD && !trig |=> st_q.st == SRS_ST_TIMEOUT && st_q.cnt == '0)
    else $error("Timeout did not start from zero");

  AST_TIMEOUT_HOLDS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q.st == SRS_ST_TIMEOUT |-> rst_n_oe)
    else $error("Reset released during timeout");

  AST_CNT_STEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && st_q.st == SRS_ST_TIMEOUT && !trig && st_q.cnt < `SRS_CNT_W'(TIMEOUT_CYC - 1)
    |=> st_q.cnt == $past(st_q.cnt) + 1'b1)
    else $error("Timeout count skipped");

  AST_REFUSED: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && wr_req && !wr_allow |=> wr_refused)
    else $error("Blocked write not refused");

  AST_ACCEPTED: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && wr_req && wr_allow |=> !wr_refused)
    else $error("Allowed write refused");

  // Freeze must cover the synchronisers too, or a stale edge leaks in
  AST_FREEZE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !ce |=> $stable(st_q))
    else $error("State moved while disabled");

  AST_OWN_PIN_IGNORED: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && st_q.st == SRS_ST_RUN && (st_q.pin_own || st_q.pin_own1) && !st_q.sup_s2 && man_db
    |=> st_q.st == SRS_ST_RUN)
    else $error("Own drive seen as outside pull");

  AST_RED_WR: assert property (@(posedge clk_sys) disable iff (sys_rst)
    REDUCED && ce && !st_q.sup_s2 && st_q.powered |=> wr_allow)
    else $error("Reduced part blocked write");

  AST_POWERED_STICKY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q.powered |=> st_q.powered)
    else $error("Power-up flag lost");

  COV_RELEASE: cover property (@(posedge clk_sys) $rose(st_q.st == SRS_ST_RUN));
  COV_MANUAL: cover property (@(posedge clk_sys) st_q.st == SRS_ST_RUN ##1 !man_db);
  COV_PIN: cover property (@(posedge clk_sys)
    st_q.st == SRS_ST_RUN && !st_q.pin_s2 && !st_q.pin_own && !st_q.pin_own1);
  COV_RESTART: cover property (@(posedge clk_sys) st_q.st == SRS_ST_TIMEOUT ##1 st_q.st == SRS_ST_HOLD);
  COV_REFUSE: cover property (@(posedge clk_sys) wr_refused);
endmodule : srs_supervisor

// ==== srs_far_end.sv ====
`timescale 1ns/1ps
module srs_far_end (
  input  wire logic press,             // Button held down
  input  wire logic pull_pin,          // Host forces reset wire low
  input  wire logic rst_n_oe,          // Device drive enable
  output logic      manual_push_input, // Button line
  output logic      rst_n_in           // Resolved reset wire
);
  // Pull-up keeps the button line high when released
  assign manual_push_input = !press;
  // Open-drain wire: low if anyone pulls, else pull-up
  assign rst_n_in = !(rst_n_oe || pull_pin);
endmodule : srs_far_end

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import srs_pkg::*;
  localparam int TO = 20;
  logic clk_sys = 0, sys_rst = 1, supply_low = 1, wp_in = 0, wr_req = 0, press = 0, pull_pin = 0, ce = 1;
  logic drv_lo, drv_hi;
  srs_state_t st_o;
  logic mpi, rst_n_in, rst_n_oe, rst_hi_oe, wr_allow, wr_refused, r_oe, r_hi, r_wa;
  int   bad_count = 0, num_checks = 0, n;
  initial forever #12.5 clk_sys = ~clk_sys;
  srs_far_end far (.press(press), .pull_pin(pull_pin), .rst_n_oe(rst_n_oe), .manual_push_input(mpi),
    .rst_n_in(rst_n_in));
  srs_supervisor #(.TIMEOUT_CYC(TO), .DEBOUNCE_CYC(4)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
    .supply_low(supply_low), .manual_push_input(mpi), .rst_n_in(rst_n_in), .wp_in(wp_in), .wr_req(wr_req),
    .rst_n_o(drv_lo), .rst_n_oe(rst_n_oe), .rst_hi_o(drv_hi), .rst_hi_oe(rst_hi_oe), .wr_allow(wr_allow),
    .wr_refused(wr_refused), .state_o(st_o));
  // Reduced variant shares stimulus; its wire sees only its own drive
  srs_supervisor #(.TIMEOUT_CYC(TO), .DEBOUNCE_CYC(4), .REDUCED(1'b1)) dut_red (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .ce(ce), .supply_low(supply_low), .manual_push_input(mpi), .rst_n_in(!r_oe),
    .wp_in(wp_in), .wr_req(wr_req), .rst_n_o(), .rst_n_oe(r_oe), .rst_hi_o(), .rst_hi_oe(r_hi),
    .wr_allow(r_wa), .wr_refused(), .state_o());

  task automatic chk(string what, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic cyc(int k);
    repeat (k) @(negedge clk_sys);
  endtask : cyc

  // Counts cycles until the enable settles; a spent bound ends the run
  task automatic wait_oe(logic v, int lim);
    n = 0;
    while (rst_n_oe !== v) begin
      cyc(1);
      n++;
      if (n > lim) begin
        chk("wait_oe", v, rst_n_oe);
        close_out();
      end
    end
  endtask : wait_oe

  initial begin
    void'($urandom(87700));
    cyc(20);
    sys_rst = 0;
    chk("power_up_oe", 1'b1, rst_n_oe);
    chk("power_up_hi", 1'b1, rst_hi_oe);
    chk("power_up_wr", 1'b0, wr_allow);
    cyc(5);
    supply_low = 0;
    wait_oe(0, 200);
    chk("release_time", 1'b1, n == TO + 3);
    chk("hi_released", 1'b0, rst_hi_oe);
    chk("red_hi", 1'b0, r_hi);
    chk("state_run", 1'b1, st_o == SRS_ST_RUN);
    chk("drv_lo", 1'b0, drv_lo);
    chk("drv_hi", 1'b1, drv_hi);
    for (int i = 0; i < 40; i++) begin
      wp_in = 1'($urandom);
      wr_req = 1'($urandom);
      cyc(2);
      chk("wr_allow", !wp_in, wr_allow);
      chk("wr_refused", wr_req & wp_in, wr_refused);
      chk("red_wr_allow", 1'b1, r_wa);
    end
    wp_in = 0;
    supply_low = 1;
    cyc(3);
    chk("dip_oe", 1'b1, rst_n_oe);
    chk("dip_hi", 1'b1, rst_hi_oe);
    chk("dip_wr", 1'b0, wr_allow);
    supply_low = 0;
    wait_oe(0, 200);
    chk("dip_release", 1'b1, n == TO + 3);
    press = 1;
    cyc(2);
    press = 0;
    cyc(12);
    chk("glitch_ignored", 1'b0, rst_n_oe);
    press = 1;
    cyc(12);
    chk("push_oe", 1'b1, rst_n_oe);
    cyc(TO + 10);
    chk("push_held", 1'b1, rst_n_oe);
    press = 0;
    wait_oe(0, 200);
    chk("push_timeout", 1'b1, n >= TO);
    pull_pin = 1;
    cyc(4);
    pull_pin = 0;
    cyc(1);
    chk("pin_trigger", 1'b1, rst_n_oe);
    wait_oe(0, 200);
    chk("pin_timeout", 1'b1, n >= TO);
    cyc(5);
    chk("pin_no_retrigger", 1'b0, rst_n_oe);
    ce = 0;
    supply_low = 1;
    cyc(5);
    chk("ce_frozen", 1'b0, rst_n_oe);
    ce = 1;
    cyc(3);
    chk("ce_resume_oe", 1'b1, rst_n_oe);
    supply_low = 0;
    wait_oe(0, 200);
    chk("ce_release", 1'b1, n == TO + 3);
    close_out();
  end
endmodule : tb_top
